// [pkg/pla_defs.svh]
// constants of the accumulator load and store datapath
`ifndef PLA_DEFS_SVH
`define PLA_DEFS_SVH
`define PLA_ACC_W 32
`define PLA_WORD_W 16
`define PLA_STACK_DEPTH 8
`define PLA_BIT_AW 12
`define PLA_CNT_W 6
`define PLA_CNT_MIN 6'h01
`define PLA_CNT_MAX 6'h20
`define PLA_MAX_IO 13'h03FF
`define PLA_MAX_CR 13'h07FF
`define PLA_MAX_STAGE 13'h03FF
`define PLA_MAX_TMR 13'h00FF
`define PLA_MAX_SP 13'h01FF
`define PLA_MAX_GIO 13'h07FF
`define PLA_LDA_LO1 16'h0300
`define PLA_LDA_HI1 16'h0EFF
`define PLA_LDA_LO2 16'h1000
`define PLA_LDA_HI2 16'h3DFF
`define PLA_OCT_DIGITS 5
`define PLA_OCT_W 20
`define PLA_NEXT_WORD 16'h0001
`endif

// [pkg/pla_pkg.sv]
// types of the accumulator load and store datapath
`include "pla_defs.svh"
package pla_pkg;
    typedef enum logic [3:0] {
        OP_FORMATTED_BIT_LOAD,
        OP_OCTAL_ADDRESS_LOAD,
        OP_WORD_INDEXED_LOAD,
        OP_CONSTANT_TABLE_INDEXED_LOAD,
        OP_REAL_NUMBER_LOAD_MEM,
        OP_REAL_NUMBER_LOAD_IMM,
        OP_WORD_STORE,
        OP_WORD_STORE_PTR,
        OP_DOUBLE_WORD_STORE
    } pla_op_t;
    typedef enum logic [2:0] {
        SPC_INPUT,
        SPC_OUTPUT,
        SPC_CONTROL_RELAY,
        SPC_STAGE,
        SPC_TIMER_BITS,
        SPC_COUNTER_BITS,
        SPC_SPECIAL_RELAYS,
        SPC_GLOBAL_IO_BITS
    } pla_space_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BIT_WAIT,
        ST_RD_LO,
        ST_RD_HI,
        ST_CONST_WAIT,
        ST_PTR_WAIT,
        ST_WR_HI
    } pla_state_t;
endpackage

// [verilog/pla_acc_stack.sv]
// eight-level push-down accumulator stack
`timescale 1ns/1ps
`default_nettype none
`include "pla_defs.svh"
module pla_acc_stack import pla_pkg::*; #(
    parameter int DEPTH = `PLA_STACK_DEPTH,
    parameter int WIDTH = `PLA_ACC_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] level1
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] lvl;
    } pla_stack_state_t;

    pla_stack_state_t s_r;
    pla_stack_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            // the deepest entry falls off and is lost
            s_nxt.lvl[0] = push_data;
            for (int i = 1; i < DEPTH; i++) begin
                s_nxt.lvl[i] = s_r.lvl[i-1];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign level1 = s_r.lvl[0];
endmodule
`default_nettype wire

// [verilog/pla_accumulator.sv]
// accumulator load and store datapath of the controller cpu
`timescale 1ns/1ps
`default_nettype none
`include "pla_defs.svh"
// What this block does
// - The formatted bit load gathers 1 to 32 consecutive discrete bits and clears every accumulator bit above them.
// - The starting discrete bit lands in accumulator bit 0 and each following bit in the next higher bit.
// - The formatted bit load accepts only offsets whose low 12 bits keep the whole run within the range of its bit space.
// - After every load the negative flag follows the sign bit of the accumulator.
// - After every load the zero-load flag is set when the loaded value is zero.
// - A load that follows a load with no store between pushes the old accumulator onto the stack first.
// - The octal address load turns octal digits into their binary value, valid for 1400-7377 and 10000-36777.
// - The word indexed load adds stack level one to the source address and loads that word zero-extended.
// - The constant table load uses stack level one as index into the named data label area (1-FFFF).
// - The real number load fills all 32 bits from two consecutive words or from an immediate.
// - The single-word store writes the low accumulator word directly or through a pointer.
// - The double-word store writes all 32 bits to two consecutive words, low word first.
// - The accumulator is 32 bits and each word location 16 bits.
// - The stack holds eight 32-bit levels and a push drops the eighth.
module pla_accumulator import pla_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire pla_op_t cmd_op,
    input wire pla_space_t cmd_space,
    input wire logic [`PLA_WORD_W-1:0] cmd_addr,
    input wire logic [`PLA_CNT_W-1:0] cmd_count,
    input wire logic [`PLA_ACC_W-1:0] cmd_imm,
    output logic done,
    output logic op_error,
    output logic [`PLA_ACC_W-1:0] acc,
    output logic negative_flag,
    output logic zero_load_flag,
    output logic [`PLA_ACC_W-1:0] stack_level1,
    output logic wm_req,
    output logic wm_we,
    output logic [`PLA_WORD_W-1:0] wm_addr,
    output logic [`PLA_WORD_W-1:0] wm_wdata,
    input wire logic wm_rvalid,
    input wire logic [`PLA_WORD_W-1:0] wm_rdata,
    output logic bm_req,
    output pla_space_t bm_space,
    output logic [`PLA_BIT_AW-1:0] bm_addr,
    input wire logic bm_rvalid,
    input wire logic bm_rdata,
    output logic ct_req,
    output logic [`PLA_WORD_W-1:0] ct_label,
    output logic [`PLA_WORD_W-1:0] ct_index,
    input wire logic ct_rvalid,
    input wire logic [`PLA_WORD_W-1:0] ct_rdata
);
    typedef struct packed {
        pla_state_t st;
        pla_op_t op;
        logic [`PLA_ACC_W-1:0] acc;
        logic neg;
        logic zero;
        logic last_load;
        logic [`PLA_WORD_W-1:0] addr;
        logic [`PLA_CNT_W-1:0] cnt;
        logic [`PLA_CNT_W-1:0] idx;
        logic [`PLA_ACC_W-1:0] gath;
        logic [`PLA_WORD_W-1:0] lo;
        logic done;
        logic err;
        logic wm_req;
        logic wm_we;
        logic [`PLA_WORD_W-1:0] wm_addr;
        logic [`PLA_WORD_W-1:0] wm_wdata;
        logic bm_req;
        pla_space_t bm_space;
        logic [`PLA_BIT_AW-1:0] bm_addr;
        logic ct_req;
        logic [`PLA_WORD_W-1:0] ct_label;
        logic [`PLA_WORD_W-1:0] ct_index;
    } pla_state_rec_t;

    pla_state_rec_t s_r;
    pla_state_rec_t s_nxt;
    logic push_c;
    logic load_fin;
    logic [`PLA_ACC_W-1:0] load_val;
    logic [`PLA_ACC_W-1:0] offset_src;

    // highest offset each discrete bit space accepts
    function automatic logic [12:0] space_max(input pla_space_t sp);
        logic [12:0] m;
        m = `PLA_MAX_IO;
        unique case (sp)
            SPC_INPUT, SPC_OUTPUT, SPC_STAGE: m = `PLA_MAX_IO;
            SPC_CONTROL_RELAY: m = `PLA_MAX_CR;
            SPC_GLOBAL_IO_BITS: m = `PLA_MAX_GIO;
            SPC_TIMER_BITS, SPC_COUNTER_BITS: m = `PLA_MAX_TMR;
            SPC_SPECIAL_RELAYS: m = `PLA_MAX_SP;
        endcase
        return m;
    endfunction

    // octal digits one per nibble; three bits per digit pack into binary
    function automatic logic [`PLA_WORD_W-1:0] oct_value(input logic [`PLA_OCT_W-1:0] d);
        logic [`PLA_WORD_W-1:0] v;
        v = '0;
        for (int i = 0; i < `PLA_OCT_DIGITS; i++) begin
            v[3*i +: 3] = d[4*i +: 3];
        end
        return v;
    endfunction

    function automatic logic oct_bad(input logic [`PLA_OCT_W-1:0] d);
        logic b;
        b = 1'b0;
        for (int i = 0; i < `PLA_OCT_DIGITS; i++) begin
            b = b | d[4*i+3];
        end
        return b;
    endfunction

    pla_acc_stack #(
        .DEPTH(`PLA_STACK_DEPTH),
        .WIDTH(`PLA_ACC_W)
    ) u_stack (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .push(push_c),
        .push_data(s_r.acc),
        .level1(stack_level1)
    );

    // a load straight after a load sees its index in the accumulator, since the push lands with it
    assign offset_src = s_r.last_load ? s_r.acc : stack_level1;

    always_comb begin
        logic [12:0] last_bit;
        logic [`PLA_WORD_W-1:0] oval;
        last_bit = '0;
        oval = '0;
        s_nxt = s_r;
        load_fin = 1'b0;
        load_val = '0;
        s_nxt.done = 1'b0;
        s_nxt.err = 1'b0;
        s_nxt.wm_req = 1'b0;
        s_nxt.wm_we = 1'b0;
        s_nxt.bm_req = 1'b0;
        s_nxt.ct_req = 1'b0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (cmd_valid) begin
                    s_nxt.op = cmd_op;
                    s_nxt.addr = cmd_addr;
                    s_nxt.cnt = cmd_count;
                    unique case (cmd_op)
                        OP_FORMATTED_BIT_LOAD: begin
                            last_bit = {1'b0, cmd_addr[`PLA_BIT_AW-1:0]} + {7'h00, cmd_count} - 13'h0001;
                            if (cmd_count < `PLA_CNT_MIN || cmd_count > `PLA_CNT_MAX ||
                                last_bit > space_max(cmd_space)) begin
                                s_nxt.err = 1'b1;
                                s_nxt.done = 1'b1;
                            end else begin
                                s_nxt.gath = '0;
                                s_nxt.idx = '0;
                                s_nxt.bm_req = 1'b1;
                                s_nxt.bm_space = cmd_space;
                                s_nxt.bm_addr = cmd_addr[`PLA_BIT_AW-1:0];
                                s_nxt.st = ST_BIT_WAIT;
                            end
                        end
                        OP_OCTAL_ADDRESS_LOAD: begin
                            oval = oct_value(cmd_imm[`PLA_OCT_W-1:0]);
                            if (oct_bad(cmd_imm[`PLA_OCT_W-1:0]) || |cmd_imm[`PLA_ACC_W-1:`PLA_OCT_W] ||
                                !((oval >= `PLA_LDA_LO1 && oval <= `PLA_LDA_HI1) ||
                                  (oval >= `PLA_LDA_LO2 && oval <= `PLA_LDA_HI2))) begin
                                s_nxt.err = 1'b1;
                                s_nxt.done = 1'b1;
                            end else begin
                                load_fin = 1'b1;
                                load_val = {16'h0000, oval};
                            end
                        end
                        OP_WORD_INDEXED_LOAD: begin
                            s_nxt.wm_req = 1'b1;
                            s_nxt.wm_addr = cmd_addr + offset_src[`PLA_WORD_W-1:0];
                            s_nxt.st = ST_RD_LO;
                        end
                        OP_CONSTANT_TABLE_INDEXED_LOAD: begin
                            if (cmd_addr == 16'h0000) begin
                                s_nxt.err = 1'b1;
                                s_nxt.done = 1'b1;
                            end else begin
                                s_nxt.ct_req = 1'b1;
                                s_nxt.ct_label = cmd_addr;
                                s_nxt.ct_index = offset_src[`PLA_WORD_W-1:0];
                                s_nxt.st = ST_CONST_WAIT;
                            end
                        end
                        OP_REAL_NUMBER_LOAD_MEM: begin
                            s_nxt.wm_req = 1'b1;
                            s_nxt.wm_addr = cmd_addr;
                            s_nxt.st = ST_RD_LO;
                        end
                        OP_REAL_NUMBER_LOAD_IMM: begin
                            load_fin = 1'b1;
                            load_val = cmd_imm;
                        end
                        OP_WORD_STORE: begin
                            s_nxt.wm_req = 1'b1;
                            s_nxt.wm_we = 1'b1;
                            s_nxt.wm_addr = cmd_addr;
                            s_nxt.wm_wdata = s_r.acc[`PLA_WORD_W-1:0];
                            s_nxt.last_load = 1'b0;
                            s_nxt.done = 1'b1;
                        end
                        OP_WORD_STORE_PTR: begin
                            s_nxt.wm_req = 1'b1;
                            s_nxt.wm_addr = cmd_addr;
                            s_nxt.st = ST_PTR_WAIT;
                        end
                        OP_DOUBLE_WORD_STORE: begin
                            s_nxt.wm_req = 1'b1;
                            s_nxt.wm_we = 1'b1;
                            s_nxt.wm_addr = cmd_addr;
                            s_nxt.wm_wdata = s_r.acc[`PLA_WORD_W-1:0];
                            s_nxt.last_load = 1'b0;
                            s_nxt.st = ST_WR_HI;
                        end
                        default: begin
                            s_nxt.err = 1'b1;
                            s_nxt.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_BIT_WAIT: begin
                if (bm_rvalid) begin
                    s_nxt.gath[s_r.idx[4:0]] = bm_rdata;
                    if (s_r.idx == s_r.cnt - `PLA_CNT_MIN) begin
                        load_fin = 1'b1;
                        load_val = s_nxt.gath;
                        s_nxt.st = ST_IDLE;
                    end else begin
                        s_nxt.idx = s_r.idx + `PLA_CNT_MIN;
                        s_nxt.bm_req = 1'b1;
                        s_nxt.bm_addr = s_r.bm_addr + {{(`PLA_BIT_AW-1){1'b0}}, 1'b1};
                    end
                end
            end
            ST_RD_LO: begin
                if (wm_rvalid) begin
                    if (s_r.op == OP_WORD_INDEXED_LOAD) begin
                        load_fin = 1'b1;
                        load_val = {16'h0000, wm_rdata};
                        s_nxt.st = ST_IDLE;
                    end else begin
                        s_nxt.lo = wm_rdata;
                        s_nxt.wm_req = 1'b1;
                        s_nxt.wm_addr = s_r.addr + `PLA_NEXT_WORD;
                        s_nxt.st = ST_RD_HI;
                    end
                end
            end
            ST_RD_HI: begin
                if (wm_rvalid) begin
                    load_fin = 1'b1;
                    load_val = {wm_rdata, s_r.lo};
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_CONST_WAIT: begin
                if (ct_rvalid) begin
                    load_fin = 1'b1;
                    load_val = {16'h0000, ct_rdata};
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_PTR_WAIT: begin
                if (wm_rvalid) begin
                    // pointer word holds a binary address, not octal
                    s_nxt.wm_req = 1'b1;
                    s_nxt.wm_we = 1'b1;
                    s_nxt.wm_addr = wm_rdata;
                    s_nxt.wm_wdata = s_r.acc[`PLA_WORD_W-1:0];
                    s_nxt.last_load = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_WR_HI: begin
                s_nxt.wm_req = 1'b1;
                s_nxt.wm_we = 1'b1;
                s_nxt.wm_addr = s_r.addr + `PLA_NEXT_WORD;
                s_nxt.wm_wdata = s_r.acc[`PLA_ACC_W-1:`PLA_WORD_W];
                s_nxt.done = 1'b1;
                s_nxt.st = ST_IDLE;
            end
        endcase
        push_c = load_fin & s_r.last_load;
        if (load_fin) begin
            s_nxt.acc = load_val;
            s_nxt.neg = load_val[`PLA_ACC_W-1];
            s_nxt.zero = (load_val == '0);
            s_nxt.last_load = 1'b1;
            s_nxt.done = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready = (s_r.st == ST_IDLE);
    assign done = s_r.done;
    assign op_error = s_r.err;
    assign acc = s_r.acc;
    assign negative_flag = s_r.neg;
    assign zero_load_flag = s_r.zero;
    assign wm_req = s_r.wm_req;
    assign wm_we = s_r.wm_we;
    assign wm_addr = s_r.wm_addr;
    assign wm_wdata = s_r.wm_wdata;
    assign bm_req = s_r.bm_req;
    assign bm_space = s_r.bm_space;
    assign bm_addr = s_r.bm_addr;
    assign ct_req = s_r.ct_req;
    assign ct_label = s_r.ct_label;
    assign ct_index = s_r.ct_index;

    sequence s_lo_write;
        wm_req && wm_we && s_r.st == ST_WR_HI && wm_wdata == acc[`PLA_WORD_W-1:0];
    endsequence
    sequence s_hi_write;
        wm_req && wm_we && wm_wdata == acc[`PLA_ACC_W-1:`PLA_WORD_W] && wm_addr == $past(wm_addr) + `PLA_NEXT_WORD;
    endsequence

    a_dstore_two_words: assert property (@(posedge clk) disable iff (rst)
        (s_lo_write and ce) |=> s_hi_write)
        else $error("double store did not write the high word next");
    a_neg_follows_sign: assert property (@(posedge clk) disable iff (rst)
        done && !op_error && s_r.last_load |-> negative_flag == acc[`PLA_ACC_W-1])
        else $error("negative flag differs from accumulator sign");
    a_zero_after_load: assert property (@(posedge clk) disable iff (rst)
        done && !op_error && s_r.last_load |-> zero_load_flag == (acc == '0))
        else $error("zero flag wrong after load");
    a_push_old_acc: assert property (@(posedge clk) disable iff (rst)
        push_c && ce |=> stack_level1 == $past(acc))
        else $error("stack level one does not hold old accumulator");
    a_ldf_upper_clear: assert property (@(posedge clk) disable iff (rst)
        done && !op_error && s_r.op == OP_FORMATTED_BIT_LOAD |-> (acc >> s_r.cnt) == '0)
        else $error("bits above the formatted count not cleared");
    a_half_loads_zext: assert property (@(posedge clk) disable iff (rst)
        done && !op_error && (s_r.op == OP_WORD_INDEXED_LOAD || s_r.op == OP_CONSTANT_TABLE_INDEXED_LOAD)
        |-> acc[`PLA_ACC_W-1:`PLA_WORD_W] == 16'h0000)
        else $error("upper half not cleared by a 16-bit load");
    a_lda_in_range: assert property (@(posedge clk) disable iff (rst)
        done && !op_error && s_r.op == OP_OCTAL_ADDRESS_LOAD |->
        (acc >= {16'h0000, `PLA_LDA_LO1} && acc <= {16'h0000, `PLA_LDA_HI1}) ||
        (acc >= {16'h0000, `PLA_LDA_LO2} && acc <= {16'h0000, `PLA_LDA_HI2}))
        else $error("address load result outside valid range");
    a_word_store_low: assert property (@(posedge clk) disable iff (rst)
        wm_req && wm_we && s_r.st == ST_IDLE && s_r.op != OP_DOUBLE_WORD_STORE |-> wm_wdata == acc[`PLA_WORD_W-1:0])
        else $error("single store did not write the low word");
    a_ldf_bit_order: assert property (@(posedge clk) disable iff (rst)
        bm_req && s_r.st == ST_BIT_WAIT |-> bm_addr == s_r.addr[`PLA_BIT_AW-1:0] + `PLA_BIT_AW'(s_r.idx))
        else $error("discrete bit address out of step with bit index");
endmodule
`default_nettype wire

// [verification/pla_mem_model.sv]
// word, discrete bit and constant table memories with selectable latency
`timescale 1ns/1ps
`default_nettype none
module pla_mem_model import pla_pkg::*; (
    input wire logic clk,
    input wire logic slow,
    input wire logic wm_req,
    input wire logic wm_we,
    input wire logic [15:0] wm_addr,
    input wire logic [15:0] wm_wdata,
    output logic wm_rvalid,
    output logic [15:0] wm_rdata,
    input wire logic bm_req,
    input wire pla_space_t bm_space,
    input wire logic [11:0] bm_addr,
    output logic bm_rvalid,
    output logic bm_rdata,
    input wire logic ct_req,
    input wire logic [15:0] ct_label,
    input wire logic [15:0] ct_index,
    output logic ct_rvalid,
    output logic [15:0] ct_rdata
);
    logic [15:0] store [logic [15:0]];
    logic [15:0] val = 16'h0000;
    logic [1:0] kind = 2'h0;
    int n = 0;
    // unwritten words hold a pattern derived from the address
    function automatic logic [15:0] wrd(input logic [15:0] a);
        return store.exists(a) ? store[a] : a * 16'h9E37 ^ 16'h5A3C;
    endfunction
    function automatic logic bit_of(input pla_space_t s, input logic [11:0] a);
        return ^(a * 12'h2B5 ^ s);
    endfunction
    function automatic logic [15:0] cst(input logic [15:0] l, input logic [15:0] i);
        return l * 16'h0101 + i * 16'h1357;
    endfunction
    task automatic take(input logic [1:0] k, input logic [15:0] v);
        kind <= k;
        val <= v;
        n <= slow ? 3 : 1;
    endtask
    initial begin
        {wm_rvalid, bm_rvalid, ct_rvalid, bm_rdata} = 4'h0;
        wm_rdata = 16'h0000;
        ct_rdata = 16'h0000;
    end
    // idle data lines toggle so a stale word never passes for an answer
    always @(posedge clk) begin
        {wm_rvalid, bm_rvalid, ct_rvalid} <= 3'h0;
        {wm_rdata, bm_rdata, ct_rdata} <= ~{wm_rdata, bm_rdata, ct_rdata};
        if (n > 0) n <= n - 1;
        if (n == 1 && kind == 0) {wm_rvalid, wm_rdata} <= {1'b1, val};
        if (n == 1 && kind == 1) {bm_rvalid, bm_rdata} <= {1'b1, val[0]};
        if (n == 1 && kind == 2) {ct_rvalid, ct_rdata} <= {1'b1, val};
        if (wm_req && wm_we) store[wm_addr] = wm_wdata;
        if (wm_req && !wm_we) take(0, wrd(wm_addr));
        if (bm_req) take(1, {15'h0000, bit_of(bm_space, bm_addr)});
        if (ct_req) take(2, cst(ct_label, ct_index));
    end
endmodule
`default_nettype wire

// [verification/plc_accumulator_load_store_tb.sv]
// self-checking bench of the accumulator load and store datapath
`timescale 1ns/1ps
`default_nettype none
`include "pla_defs.svh"
module plc_accumulator_load_store_tb import pla_pkg::*;;
    logic clk, rst, ce, cmd_valid, cmd_ready, done, op_error, negative_flag, zero_load_flag, pl, slow;
    logic wm_req, wm_we, wm_rvalid, bm_req, bm_rvalid, bm_rdata, ct_req, ct_rvalid;
    pla_op_t cmd_op;
    pla_space_t cmd_space, bm_space;
    logic [15:0] cmd_addr, wm_addr, wm_wdata, wm_rdata, ct_label, ct_index, ct_rdata, a, p;
    logic [5:0] cmd_count;
    logic [11:0] bm_addr, mx, st;
    logic [31:0] cmd_imm, acc, stack_level1, ea, es, r;
    int n_fail, num_checks;
    pla_accumulator uut (.clk, .rst, .ce, .cmd_valid, .cmd_ready, .cmd_op, .cmd_space, .cmd_addr,
        .cmd_count, .cmd_imm, .done, .op_error, .acc, .negative_flag, .zero_load_flag, .stack_level1,
        .wm_req, .wm_we, .wm_addr, .wm_wdata, .wm_rvalid, .wm_rdata, .bm_req, .bm_space, .bm_addr,
        .bm_rvalid, .bm_rdata, .ct_req, .ct_label, .ct_index, .ct_rvalid, .ct_rdata);
    pla_mem_model mem (.clk, .slow, .wm_req, .wm_we, .wm_addr, .wm_wdata, .wm_rvalid, .wm_rdata,
        .bm_req, .bm_space, .bm_addr, .bm_rvalid, .bm_rdata, .ct_req, .ct_label, .ct_index,
        .ct_rvalid, .ct_rdata);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] oct(input logic [15:0] v);
        logic [31:0] o = 32'h0;
        for (int i = 0; i < 5; i++) o[4*i+:4] = {1'b0, v[3*i+:3]};
        return o;
    endfunction
    function automatic logic [11:0] maxof(input pla_space_t s);
        case (s)
            SPC_CONTROL_RELAY, SPC_GLOBAL_IO_BITS: return `PLA_MAX_CR;
            SPC_TIMER_BITS, SPC_COUNTER_BITS: return `PLA_MAX_TMR;
            SPC_SPECIAL_RELAYS: return `PLA_MAX_SP;
            default: return `PLA_MAX_IO;
        endcase
    endfunction
    function automatic logic [31:0] gath(input pla_space_t s, input logic [11:0] b, input int c);
        logic [31:0] g = 32'h0;
        for (int i = 0; i < c; i++) g[i] = mem.bit_of(s, b + 12'(i));
        return g;
    endfunction
    function automatic logic [15:0] off();
        return pl ? ea[15:0] : es[15:0];
    endfunction
    task automatic cmd(input pla_op_t op, input pla_space_t sp, input logic [15:0] ad, input logic [5:0] c,
                       input logic [31:0] im);
        int k = 0;
        @(posedge clk);
        {cmd_valid, cmd_op, cmd_space, cmd_addr, cmd_count, cmd_imm} <= {1'b1, op, sp, ad, c, im};
        slow <= $urandom % 2;
        @(posedge clk);
        cmd_valid <= 1'b0;
        do begin
            @(negedge clk);
            k++;
        end while (done !== 1'b1 && k < 200);
        chk("done_seen", k < 200, 1);
    endtask
    task automatic ld(input pla_op_t op, input pla_space_t sp, input logic [15:0] ad, input logic [5:0] c,
                      input logic [31:0] im, input logic [31:0] v);
        cmd(op, sp, ad, c, im);
        if (pl) es = ea;
        ea = v;
        pl = 1'b1;
        chk("op_error", op_error, 0);
        chk("acc", acc, ea);
        chk("negative_flag", negative_flag, ea[31]);
        chk("zero_load_flag", zero_load_flag, ea == 0);
        chk("stack_level1", stack_level1, es);
    endtask
    task automatic bad(input pla_op_t op, input pla_space_t sp, input logic [15:0] ad, input logic [5:0] c,
                       input logic [31:0] im);
        cmd(op, sp, ad, c, im);
        chk("refused", op_error, 1);
        chk("acc_kept", {|(acc ^ ea), |(stack_level1 ^ es)}, 0);
    endtask
    task automatic sto(input pla_op_t op, input logic [15:0] ad);
        cmd(op, SPC_INPUT, ad, 6'h00, 32'h0);
        // memory takes the last write one edge after done
        @(negedge clk);
        pl = 1'b0;
        chk("store_keeps", {|(acc ^ ea), negative_flag, zero_load_flag}, {1'b0, ea[31], ea == 0});
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200us;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {rst, ce, cmd_valid, cmd_count, cmd_imm, cmd_addr, slow, pl} = {3'b110, 56'h0};
        cmd_op = OP_WORD_STORE;
        cmd_space = SPC_INPUT;
        {ea, es, n_fail, num_checks} = 0;
        void'($urandom(32'h4404));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset", {|acc, |stack_level1, negative_flag, zero_load_flag, cmd_ready}, 1);
        chk("acc_width", $bits(acc), 32);
        foreach (r[i]) ld(OP_OCTAL_ADDRESS_LOAD, SPC_INPUT, 0, 0, oct(i[15:0] * 16'h0123 + `PLA_LDA_LO2), i * 32'h0123 + 32'h1000);
        ld(OP_OCTAL_ADDRESS_LOAD, SPC_INPUT, 0, 0, oct(`PLA_LDA_LO1), `PLA_LDA_LO1);
        ld(OP_OCTAL_ADDRESS_LOAD, SPC_INPUT, 0, 0, oct(`PLA_LDA_HI1), `PLA_LDA_HI1);
        ld(OP_OCTAL_ADDRESS_LOAD, SPC_INPUT, 0, 0, oct(`PLA_LDA_HI2), `PLA_LDA_HI2);
        r = $urandom;
        foreach (r[i]) bad(OP_OCTAL_ADDRESS_LOAD, SPC_INPUT, 0, 0, r[i] ? oct(16'h02FF) + i : 32'h00F00 << (i % 3));
        bad(OP_OCTAL_ADDRESS_LOAD, SPC_INPUT, 0, 0, oct(16'h3E00));
        bad(OP_CONSTANT_TABLE_INDEXED_LOAD, SPC_INPUT, 0, 0, 0);
        for (int s = 0; s < 8; s++) begin
            mx = maxof(pla_space_t'(s));
            r = 1 + $urandom % 32;
            st = $urandom % (mx - r[11:0] + 2);
            ld(OP_FORMATTED_BIT_LOAD, pla_space_t'(s), st, r[5:0], 0, gath(pla_space_t'(s), st, r));
            ld(OP_FORMATTED_BIT_LOAD, pla_space_t'(s), mx - 31, 32, 0, gath(pla_space_t'(s), mx - 31, 32));
            bad(OP_FORMATTED_BIT_LOAD, pla_space_t'(s), mx - 30, 32, 0);
            bad(OP_FORMATTED_BIT_LOAD, pla_space_t'(s), 0, 6'(s % 2 ? 0 : 33), 0);
        end
        ld(OP_REAL_NUMBER_LOAD_IMM, SPC_INPUT, 0, 0, 32'h0, 32'h0);
        for (int i = 0; i < 90; i++) begin
            a = $urandom;
            r = $urandom;
            case ($urandom % 7)
                0: ld(OP_REAL_NUMBER_LOAD_IMM, SPC_INPUT, a, 0, r, r);
                1: ld(OP_REAL_NUMBER_LOAD_MEM, SPC_INPUT, a, 0, 0, {mem.wrd(a + 16'h1), mem.wrd(a)});
                2: ld(OP_WORD_INDEXED_LOAD, SPC_INPUT, a, 0, 0, {16'h0, mem.wrd(a + off())});
                3: ld(OP_CONSTANT_TABLE_INDEXED_LOAD, SPC_INPUT, a | 16'h1, 0, 0, {16'h0, mem.cst(a | 16'h1, off())});
                4: begin
                    sto(OP_WORD_STORE, a);
                    chk("word_store", mem.wrd(a), ea[15:0]);
                end
                5: begin
                    sto(OP_DOUBLE_WORD_STORE, a);
                    chk("double_store", {mem.wrd(a + 16'h1), mem.wrd(a)}, ea);
                end
                default: begin
                    p = mem.wrd(a);
                    sto(OP_WORD_STORE_PTR, a);
                    chk("pointer_store", mem.wrd(p), ea[15:0]);
                end
            endcase
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
